// ===== rtl/idm_defines.svh
`ifndef IDM_DEFINES_SVH
`define IDM_DEFINES_SVH
// special function addresses handled here
`define IDM_ADDR_STACK_POINTER 8'h81
`define IDM_ADDR_STATUS_WORD   8'hd0
// reset values
`define IDM_RST_STACK_POINTER  8'h07
`define IDM_RST_STATUS_WORD    8'h00
// field positions
`define IDM_BANK_LOW_BIT       3
`define IDM_BANK_HIGH_BIT      4
// region boundaries
`define IDM_LOWER_TOP          8'h7f
`define IDM_BIT_REGION_BASE    8'h20
`endif

// ===== rtl/idm_pkg.sv
package idm_pkg;
    // addressing mode of an access
    typedef enum logic [1:0] {
        IDM_DIRECT,
        IDM_INDIRECT,
        IDM_REGISTER
    } idm_mode_e;
    // stack operation
    typedef enum logic [1:0] {
        IDM_STACK_NONE,
        IDM_STACK_PUSH,
        IDM_STACK_POP
    } idm_stack_e;
    typedef logic [7:0] idm_byte_t;
endpackage : idm_pkg

// ===== rtl/idm_data_memory.sv
// Function
// - 256 bytes of RAM, 0x00 to 0xff
// - lower half by direct or indirect
// - upper half RAM only via indirect or the stack
// - direct above 0x7f goes to special space
// - indirect above 0x7f goes to upper RAM
// - lowest 32 bytes are four register banks
// - one bank, chosen by status bits 3,4
// - indirect address from index register zero/one
// - 0x20-0x2f also 128 addressable bits
// - bit address is eight times offset plus bit
// - bit or byte chosen by operand type
// - stack anywhere, pointer holds last used
// - push writes pointer plus one, then increments
// - reset loads stack pointer with 0x07
// - stack may span all 256 bytes
`include "idm_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module idm_data_memory (
    input  wire logic               ref_clk,       // system clock
    input  wire logic               nrst,          // sync reset, active low
    input  wire logic               accValid,      // access request this cycle
    input  wire logic               accWrite,      // 1 write, 0 read
    input  wire idm_pkg::idm_mode_e accMode,       // addressing mode
    input  wire logic               accBit,        // operand type is bit
    input  wire logic [7:0]         accAddr,       // byte/bit address or index sel
    input  wire logic [7:0]         accWdata,      // write data, bit in [0]
    input  wire idm_pkg::idm_stack_e stackOp,      // push or pop
    input  wire logic [7:0]         stackWdata,    // value to push
    output logic [7:0]              rdata,         // read data, registered
    output logic                    rvalid,        // read data valid pulse
    output logic                    sfrSel,        // access went to external special register
    output logic [7:0]              sfrAddr,       // special space address
    output logic                    sfrWrite,      // special space write strobe
    output logic [7:0]              sfrWdata,      // special space write data
    input  wire logic [7:0]         sfrRdata,      // special space read data
    output logic [7:0]              stack_pointer, // stack pointer register
    output logic [7:0]              program_status_word, // status word register
    output logic [1:0]              activeBank     // current register bank
);
    import idm_pkg::*;

    // 256-byte RAM
    // full ram array
    logic [7:0] ram [0:255];

    logic [7:0] indexAddr;    // address held in index register
    logic [7:0] effAddr;      // resolved byte address
    logic       toSfr;        // direct access above lower half
    logic [2:0] bitPos;       // bit position within byte
    logic       isLocalSfr;   // stack pointer or status word
    logic [7:0] next_sp;      // stack pointer after this cycle
    logic [7:0] pushAddr;     // location of next push

    // bank select from status word
    // bank from status bits
    assign activeBank = {program_status_word[`IDM_BANK_HIGH_BIT], program_status_word[`IDM_BANK_LOW_BIT]};

    // register address within the active bank
    function automatic logic [7:0] bankReg(input logic [1:0] bank, input logic [2:0] num);
        bankReg = {3'h0, bank, num};
    endfunction : bankReg

    // index register zero or one of active bank
    // index register lookup
    assign indexAddr = ram[bankReg(activeBank, {2'h0, accAddr[0]})];

    // bit address to byte address
    function automatic logic [7:0] bitByte(input logic [7:0] bitAddr);
        bitByte = `IDM_BIT_REGION_BASE + {4'h0, bitAddr[6:3]};
    endfunction : bitByte

    // resolve address and target
    always_comb begin
        effAddr = accAddr;
        toSfr   = 1'b0;
        bitPos  = 3'h0;
        // operand type picks bit or byte
        if (accBit) begin
            if (accAddr <= `IDM_LOWER_TOP) begin
                effAddr = bitByte(accAddr);
            end else begin
                // bit access in special space
                effAddr = {accAddr[7:3], 3'h0};
                toSfr   = 1'b1;
            end
            bitPos = accAddr[2:0];
        end else if (accMode == IDM_INDIRECT) begin
            effAddr = indexAddr;
        end else if (accMode == IDM_REGISTER) begin
            // working register of active bank
            effAddr = bankReg(activeBank, accAddr[2:0]);
        end else begin
            toSfr = (accAddr > `IDM_LOWER_TOP);
        end
    end

    assign isLocalSfr = (effAddr == `IDM_ADDR_STACK_POINTER) || (effAddr == `IDM_ADDR_STATUS_WORD);
    assign pushAddr   = stack_pointer + 8'h01;

    // next stack pointer
    always_comb begin
        next_sp = stack_pointer;
        if (stackOp == IDM_STACK_PUSH) begin
            next_sp = pushAddr;
        end else if (stackOp == IDM_STACK_POP) begin
            next_sp = stack_pointer - 8'h01;
        end else if (accValid && accWrite && toSfr && !accBit && effAddr == `IDM_ADDR_STACK_POINTER) begin
            // software write to pointer
            next_sp = accWdata;
        end
    end

    // stack pointer register
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            stack_pointer <= `IDM_RST_STACK_POINTER;
        end else begin
            stack_pointer <= next_sp;
        end
    end

    // status word register
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            program_status_word <= `IDM_RST_STATUS_WORD;
        end else if (accValid && accWrite && toSfr && effAddr == `IDM_ADDR_STATUS_WORD) begin
            if (accBit) begin
                // single bit write
                program_status_word[bitPos] <= accWdata[0];
            end else begin
                // whole byte write
                program_status_word <= accWdata;
            end
        end
    end

    // ram writes, push has priority over access
    always_ff @(posedge ref_clk) begin
        if (stackOp == IDM_STACK_PUSH) begin
            ram[pushAddr] <= stackWdata;
        end else if (accValid && accWrite && !toSfr) begin
            if (accBit) begin
                // bit write keeps other bits
                ram[effAddr][bitPos] <= accWdata[0];
            end else begin
                ram[effAddr] <= accWdata;
            end
        end
    end

    // special space strobes for external registers
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sfrSel   <= 1'b0;
            sfrAddr  <= 8'h00;
            sfrWrite <= 1'b0;
            sfrWdata <= 8'h00;
        end else begin
            sfrSel   <= accValid && toSfr && !isLocalSfr;
            sfrAddr  <= effAddr;
            sfrWrite <= accValid && accWrite && toSfr && !isLocalSfr;
            sfrWdata <= accWdata;
        end
    end

    // read data path
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= (accValid && !accWrite) || (stackOp == IDM_STACK_POP);
            if (stackOp == IDM_STACK_POP) begin
                rdata <= ram[stack_pointer];
            end else if (accValid && !accWrite) begin
                if (toSfr && effAddr == `IDM_ADDR_STACK_POINTER) begin
                    rdata <= accBit ? {7'h00, stack_pointer[bitPos]} : stack_pointer;
                end else if (toSfr && effAddr == `IDM_ADDR_STATUS_WORD) begin
                    rdata <= accBit ? {7'h00, program_status_word[bitPos]} : program_status_word;
                end else if (toSfr) begin
                    // external register answers same cycle
                    rdata <= accBit ? {7'h00, sfrRdata[bitPos]} : sfrRdata;
                end else begin
                    rdata <= accBit ? {7'h00, ram[effAddr][bitPos]} : ram[effAddr];
                end
            end
        end
    end
endmodule : idm_data_memory
`default_nettype wire

// ===== dv/idm_data_memory_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module idm_data_memory_asserts (
    input wire logic                ref_clk,
    input wire logic                nrst,
    input wire logic                accValid,
    input wire logic                accWrite,
    input wire idm_pkg::idm_mode_e  accMode,
    input wire logic                accBit,
    input wire logic [7:0]          accAddr,
    input wire idm_pkg::idm_stack_e stackOp,
    input wire logic                rvalid,
    input wire logic                sfrSel,
    input wire logic [7:0]          sfrAddr,
    input wire logic [7:0]          stack_pointer,
    input wire logic [7:0]          program_status_word,
    input wire logic [1:0]          activeBank
);
    import idm_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_bank; activeBank == program_status_word[4:3]; endproperty
    a_bank: assert property (p_bank) else $error("bank select wrong");
    property p_rst; disable iff (1'h0) !nrst |=> stack_pointer == 8'h07; endproperty
    a_rst: assert property (p_rst) else $error("pointer reset wrong");
    property p_push; stackOp == IDM_STACK_PUSH |=> stack_pointer == $past(stack_pointer) + 8'h01; endproperty
    a_push: assert property (p_push) else $error("push step wrong");
    property p_pop; stackOp == IDM_STACK_POP |=> stack_pointer == $past(stack_pointer) - 8'h01; endproperty
    a_pop: assert property (p_pop) else $error("pop step wrong");
    property p_sfr; accValid && !accBit && accMode == IDM_DIRECT && accAddr[7] && accAddr != 8'h81
        && accAddr != 8'hd0 && stackOp == IDM_STACK_NONE |=> sfrSel && sfrAddr == $past(accAddr); endproperty
    a_sfr: assert property (p_sfr) else $error("direct high not special");
    property p_ind; accValid && !accBit && accMode == IDM_INDIRECT |=> !sfrSel; endproperty
    a_ind: assert property (p_ind) else $error("indirect left RAM");
    property p_low; accValid && accMode == IDM_DIRECT && !accAddr[7] |=> !sfrSel; endproperty
    a_low: assert property (p_low) else $error("low direct left RAM");
    property p_rd; accValid && !accWrite && stackOp == IDM_STACK_NONE |=> rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
endmodule : idm_data_memory_asserts
bind idm_data_memory idm_data_memory_asserts u_chk (.ref_clk(ref_clk), .nrst(nrst), .accValid(accValid),
    .accWrite(accWrite), .accMode(accMode), .accBit(accBit), .accAddr(accAddr), .stackOp(stackOp),
    .rvalid(rvalid), .sfrSel(sfrSel), .sfrAddr(sfrAddr), .stack_pointer(stack_pointer),
    .program_status_word(program_status_word), .activeBank(activeBank));
`default_nettype wire

// ===== dv/idm_special_model.sv
`timescale 1ns/100ps
`default_nettype none
module idm_special_model (
    input  wire logic [7:0] accAddr,
    output logic [7:0]      sfrRdata
);
    // answers in the request cycle; pattern differs from address
    assign sfrRdata = accAddr ^ 8'h5a;
endmodule : idm_special_model
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h", n, e, s); end end
module tb_top;
    import idm_pkg::*;
    logic ref_clk = 1'h0, nrst = 1'h0, accValid = 1'h0, accWrite = 1'h0, accBit = 1'h0, rvalid, sfrSel, sfrWrite, sel;
    logic rv, sw;
    logic [7:0] swd;
    idm_mode_e accMode = IDM_DIRECT;
    idm_stack_e stackOp = IDM_STACK_NONE;
    logic [7:0] accAddr = 8'h00, accWdata = 8'h00, stackWdata = 8'h00, sfrRdata, rdata, sfrAddr, sfrWdata, rd;
    logic [7:0] stack_pointer, program_status_word;
    logic [1:0] activeBank;
    int num_errors = 0, checks_done = 0;
    // 100 ns system clock
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    idm_data_memory dut (.ref_clk(ref_clk), .nrst(nrst), .accValid(accValid), .accWrite(accWrite), .accMode(accMode),
        .accBit(accBit), .accAddr(accAddr), .accWdata(accWdata), .stackOp(stackOp), .stackWdata(stackWdata),
        .rdata(rdata), .rvalid(rvalid), .sfrSel(sfrSel), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
        .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .stack_pointer(stack_pointer),
        .program_status_word(program_status_word), .activeBank(activeBank));
    idm_special_model u_sfr (.accAddr(accAddr), .sfrRdata(sfrRdata));
    // one request, answer captured one cycle later
    task automatic op(input logic w, input idm_mode_e m, input logic b, input logic [7:0] a, d, input idm_stack_e s);
        accValid <= (s == IDM_STACK_NONE);
        accWrite <= w;
        accMode <= m;
        accBit <= b;
        accAddr <= a;
        accWdata <= d;
        stackOp <= s;
        stackWdata <= d;
        @(posedge ref_clk);
        accValid <= 1'h0;
        stackOp <= IDM_STACK_NONE;
        #1;
        rd = rdata;
        sel = sfrSel;
        rv = rvalid;
        sw = sfrWrite;
        swd = sfrWdata;
        @(posedge ref_clk);
    endtask : op
    task automatic wr(input idm_mode_e m, input logic [7:0] a, d);
        op(1'h1, m, 1'h0, a, d, IDM_STACK_NONE);
    endtask : wr
    task automatic rc(input idm_mode_e m, input logic b, input logic [7:0] a, e);
        op(1'h0, m, b, a, 8'h00, IDM_STACK_NONE);
        `CHK("rdata", e, rd)
        `CHK("rvalid", 1'h1, rv)
    endtask : rc
    task results;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results
    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'h1;
        `CHK("sp", 8'h07, stack_pointer)
        rc(IDM_DIRECT, 1'h0, 8'h81, 8'h07);
        wr(IDM_DIRECT, 8'h00, 8'h30);
        wr(IDM_DIRECT, 8'h30, 8'ha5);
        rc(IDM_INDIRECT, 1'h0, 8'h00, 8'ha5);
        wr(IDM_DIRECT, 8'h01, 8'h90);
        wr(IDM_INDIRECT, 8'h01, 8'h3c);
        rc(IDM_INDIRECT, 1'h0, 8'h01, 8'h3c);
        rc(IDM_DIRECT, 1'h0, 8'h90, 8'hca);
        `CHK("sfrSel", 1'h1, sel)
        wr(IDM_DIRECT, 8'h90, 8'h3e);
        `CHK("sfrWrite", 1'h1, sw)
        `CHK("sfrWdata", 8'h3e, swd)
        for (int b = 0; b < 4; b++) begin
            wr(IDM_DIRECT, 8'hd0, 8'(b << 3));
            `CHK("bank", 2'(b), activeBank)
            wr(IDM_REGISTER, 8'h02, 8'(8'h60 + b));
            rc(IDM_DIRECT, 1'h0, 8'(8 * b + 2), 8'(8'h60 + b));
        end
        wr(IDM_DIRECT, 8'hd0, 8'h00);
        wr(IDM_DIRECT, 8'h22, 8'h00);
        wr(IDM_DIRECT, 8'h2f, 8'h00);
        op(1'h1, IDM_DIRECT, 1'h1, 8'h13, 8'h01, IDM_STACK_NONE);
        op(1'h1, IDM_DIRECT, 1'h1, 8'h7f, 8'h01, IDM_STACK_NONE);
        rc(IDM_DIRECT, 1'h0, 8'h22, 8'h08);
        rc(IDM_DIRECT, 1'h0, 8'h2f, 8'h80);
        rc(IDM_DIRECT, 1'h1, 8'h13, 8'h01);
        op(1'h0, IDM_DIRECT, 1'h0, 8'h00, 8'hc1, IDM_STACK_PUSH);
        `CHK("sp", 8'h08, stack_pointer)
        rc(IDM_DIRECT, 1'h0, 8'h08, 8'hc1);
        op(1'h0, IDM_DIRECT, 1'h0, 8'h00, 8'h00, IDM_STACK_POP);
        `CHK("pop", 8'hc1, rd)
        `CHK("sp", 8'h07, stack_pointer)
        wr(IDM_DIRECT, 8'h81, 8'hfe);
        op(1'h0, IDM_DIRECT, 1'h0, 8'h00, 8'h7e, IDM_STACK_PUSH);
        wr(IDM_DIRECT, 8'h01, 8'hff);
        rc(IDM_INDIRECT, 1'h0, 8'h01, 8'h7e);
        results();
    end
    // hang guard, well past the expected run
    initial begin
        repeat (400) @(posedge ref_clk);
        num_errors++;
        results();
    end
endmodule : tb_top
`default_nettype wire
